// ==== tb.sv ====
// Self-checking bench for the three-timer block over AXI4-Lite.
// Assumes the pin model drives all timer pins.
`timescale 1ns/10ps
module tb;
	logic        aclk = 1'b0;
	logic        aresetn = 1'b0;
	logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic [3:0]  s_axi_wstrb = 4'hf;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic [2:0]  timer_input_pin, external_direction_input, timer_irq;
	logic        toggle_output_pin, toggle_output_oe, irq;
	int          fail_count = 0, compares = 0, cyc = 0, seed, i, n, m, e;
	logic [31:0] d, v;
	logic [1:0]  r;
	int          modes[5] = '{1, 4, 5, 6, 7};

	ttc_top u_ttc_top (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .timer_input_pin,
		.external_direction_input, .toggle_output_pin, .toggle_output_oe, .timer_irq, .irq);
	ttc_pin_model u_ttc_pin_model (.aclk, .timer_input_pin, .external_direction_input);

	always #2.5 aclk = ~aclk;

	task automatic close_out;
		$display("compares %0d fail_count %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// A hang in any wait below ends here
	always @(posedge aclk) begin
		cyc++;
		if (cyc == 20000) begin
			fail_count++;
			close_out();
		end
	end
	task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] g);
		compares++;
		if (g !== ex) begin
			fail_count++;
			$display("Error %s expected %h seen %h", nm, ex, g);
		end
	endtask
	task automatic wr(input int a, input logic [31:0] dat);
		logic aw, w;
		aw = 1'b1;
		w = 1'b1;
		s_axi_awaddr <= 8'(a);
		s_axi_wdata <= dat;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (aw || w) begin
			@(posedge aclk);
			if (aw && s_axi_awready) begin
				aw = 1'b0;
				s_axi_awvalid <= 1'b0;
			end
			if (w && s_axi_wready) begin
				w = 1'b0;
				s_axi_wvalid <= 1'b0;
			end
		end
		do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	task automatic rd(input int a);
		s_axi_araddr <= 8'(a);
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge aclk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
	function automatic int div_of(input int s);
		return (s == 0) ? 8 : (s == 1) ? 4 : (s == 2) ? 32 : 16;
	endfunction

	initial begin
		seed = 32'h5681b1ae;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rd(8'h00);
		chk("core control", 32'h0, d);
		rd(8'h30);
		chk("unmapped read resp", 32'h2, r);
		wr(8'h30, 32'h0);
		chk("unmapped write resp", 32'h2, r);
		for (i = 0; i < 3; i++) begin
			v = $random(seed);
			wr(8'h0c + 4 * i, v);
			chk("write resp", 32'h0, r);
			rd(8'h0c + 4 * i);
			chk("count", {16'h0, v[15:0]}, d);
		end
		$display("test reset and count access done");
		for (i = 0; i < 8; i++) begin
			u_ttc_pin_model.dir(0, i[2]);
			wr(8'h00, (i[1] << 8) | (i[0] << 7));
			repeat (4) @(posedge aclk);
			rd(8'h00);
			chk("direction", i[1] ? i[2] ^ i[0] : i[0], d[15]);
		end
		u_ttc_pin_model.dir(0, 1'b0);
		$display("test direction done");
		wr(8'h1c, 32'h1);
		wr(8'h08, 32'h240);
		wr(8'h14, 32'h0);
		wr(8'h0c, 32'hfffe);
		wr(8'h00, 32'h0a40);
		for (n = 0; n < 40 && timer_irq[0] !== 1'b1; n++) @(posedge aclk);
		chk("wrap seen", 1, n < 40);
		@(posedge aclk);
		chk("irq pulse end", 0, timer_irq[0]);
		repeat (3) @(posedge aclk);
		chk("irq", 1, irq);
		chk("output pin", 1, toggle_output_pin);
		chk("output enable", 1, toggle_output_oe);
		wr(8'h00, 32'h0600);
		rd(8'h18);
		chk("status", 32'h1, d);
		rd(8'h14);
		chk("chained count", 32'h1, d);
		wr(8'h1c, 32'h0);
		@(posedge aclk);
		chk("irq masked", 0, irq);
		wr(8'h1c, 32'h1);
		wr(8'h18, 32'h1);
		@(posedge aclk);
		chk("irq cleared", 0, irq);
		$display("test wrap done");
		for (i = 0; i < 4; i++) begin
			u_ttc_pin_model.level(0, 1'b0);
			wr(8'h0c, 32'h0);
			wr(8'h00, (i << 11) | 32'h58);
			repeat (40) @(posedge aclk);
			rd(8'h0c);
			chk("gate closed", 32'h0, d);
			u_ttc_pin_model.level(0, 1'b1);
			repeat (128) @(posedge aclk);
			u_ttc_pin_model.level(0, 1'b0);
			repeat (6) @(posedge aclk);
			rd(8'h0c);
			e = 128 / div_of(i);
			chk("rate", 1, d >= e - 1 && d <= e + 1);
		end
		$display("test prescaler done");
		for (m = 0; m < 5; m++) begin
			wr(8'h10, 32'h0);
			wr(8'h04, 32'h43 | (modes[m] << 3));
			n = 1 + ($unsigned($random(seed)) % 5);
			u_ttc_pin_model.pulses(1, n);
			repeat (8) @(posedge aclk);
			rd(8'h10);
			chk("mode count", (modes[m] inside {4, 5}) ? 0 : 2 * n, d);
		end
		$display("test modes done");
		// Core is gated shut here, so its count stands still for the capture
		v = $random(seed);
		wr(8'h0c, v);
		wr(8'h04, 32'h600);
		u_ttc_pin_model.pulses(1, 1);
		rd(8'h10);
		chk("capture", {16'h0, v[15:0]}, d);
		wr(8'h04, 32'h400);
		wr(8'h0c, 32'hffff);
		wr(8'h00, 32'h0840);
		for (n = 0; n < 40 && timer_irq[0] !== 1'b1; n++) @(posedge aclk);
		chk("reload wrap", 1, n < 40);
		// Read lands before the next quarter tick can step the reloaded count
		rd(8'h0c);
		chk("reload", {16'h0, v[15:0]}, d);
		$display("test aux functions done");
		close_out();
	end
endmodule

// ==== ttc_defs.svh ====
// Offsets, field positions, reset values and timing counts of the three-timer block.
// Included by the ttc_timer and ttc_top design files; holds definitions only.
// Operation
// - Three independent 16-bit up/down timers: one core, two auxiliary.
// - No timer counts faster than once per four module clocks.
// - Each timer picks timer, gated, counter or incremental mode on its own.
// - Each timer has its own control register.
// - The input pin gates in gated mode and gives count events in counter mode.
// - Timers count up or down, set by software or the direction pin.
// - Core wraps toggle a latch, driven onto the output pin when enabled.
// - Auxiliary timers chain on latch transitions, or reload or capture the core.
// - Software may read and overwrite every count register at any time.
// - A software write beats a same-cycle step, reload or capture.
// - Each timer drives its own interrupt request line.
// - Mode codes: 000 timer, 001 counter, 010/011 gated, 110/111 incremental.
// - Counting needs the run bit, and in gated mode without chaining the active gate level.
// - Direction: software bit, or pin xor software bit when the pin is enabled.
// - Block prescaler select 00 /8, 01 /4, 10 /32, 11 /16.
`ifndef TTC_DEFS_SVH
`define TTC_DEFS_SVH

`define TTC_CNT_W      16
`define TTC_OFF_CTRL0  8'h00
`define TTC_OFF_CTRL1  8'h04
`define TTC_OFF_CTRL2  8'h08
`define TTC_OFF_CNT0   8'h0c
`define TTC_OFF_CNT1   8'h10
`define TTC_OFF_CNT2   8'h14
`define TTC_OFF_STS    8'h18
`define TTC_OFF_MSK    8'h1c

`define TTC_F_BPS_HI   12
`define TTC_F_BPS_LO   11
`define TTC_F_LATCH    10
`define TTC_F_AUX_HI   10
`define TTC_F_AUX_LO   9
`define TTC_F_OE       9
`define TTC_F_UDE      8
`define TTC_F_UD       7
`define TTC_F_RUN      6
`define TTC_F_MODE_HI  5
`define TTC_F_MODE_LO  3
`define TTC_F_EDGE_HI  1
`define TTC_F_EDGE_LO  0

`define TTC_RST_CTRL   16'h0000
`define TTC_RST_CNT    16'h0000

`define TTC_MIN_DIV    4
`define TTC_DIV_SEL0   8
`define TTC_DIV_SEL1   4
`define TTC_DIV_SEL2   32
`define TTC_DIV_SEL3   16

`define TTC_RESP_OKAY  2'h0
`define TTC_RESP_ERR   2'h2

`endif

// ==== ttc_pin_model.sv ====
// Far-side model of the timer block's gate, count and direction pins.
// Assumes the caller enters its tasks just after a rising edge of aclk.
`timescale 1ns/10ps
module ttc_pin_model (
	// Clock
	input  wire logic  aclk,
	// Pins toward the block
	output logic [2:0] timer_input_pin,
	output logic [2:0] external_direction_input
);
	initial begin
		timer_input_pin = 3'h0;
		external_direction_input = 3'h0;
	end
	task automatic level(input int i, input logic v);
		@(posedge aclk);
		timer_input_pin[i] <= v;
	endtask
	task automatic dir(input int i, input logic v);
		@(posedge aclk);
		external_direction_input[i] <= v;
	endtask
	// Each level held six clocks so that every edge is counted
	task automatic pulses(input int i, input int n);
		repeat (n) begin
			level(i, 1'b1);
			repeat (5) @(posedge aclk);
			level(i, 1'b0);
			repeat (5) @(posedge aclk);
		end
	endtask
endmodule

// ==== ttc_pkg.sv ====
// Types shared by the timer block: mode and auxiliary function codes.
// Encodings equal the control register field values.
package ttc_pkg;
	typedef enum logic [2:0] {
		TTC_M_TIMER   = 3'h0,
		TTC_M_COUNTER = 3'h1,
		TTC_M_GATE_LO = 3'h2,
		TTC_M_GATE_HI = 3'h3,
		TTC_M_INC_ROT = 3'h6,
		TTC_M_INC_EDG = 3'h7
	} ttc_mode_t;

	typedef enum logic [1:0] {
		TTC_AUX_SOLO    = 2'h0,
		TTC_AUX_CONCAT  = 2'h1,
		TTC_AUX_RELOAD  = 2'h2,
		TTC_AUX_CAPTURE = 2'h3
	} ttc_aux_t;
endpackage

// ==== ttc_timer.sv ====
// One 16-bit up/down timer with mode decode and overwrite priority.
// Assumes synchronised pin levels and one-cycle strobes from the top level.
`timescale 1ns/10ps
`include "ttc_defs.svh"
module ttc_timer #(
	parameter int W = `TTC_CNT_W
) (
	// Clock and reset
	input  wire logic               aclk,
	input  wire logic               aresetn,
	// Configuration
	input  wire ttc_pkg::ttc_mode_t mode,
	input  wire logic [1:0]         edge_sel,
	input  wire logic               run,
	input  wire logic               down,
	// Count sources
	input  wire logic               base_tick,
	input  wire logic               q4_tick,
	input  wire logic               in_lvl,
	input  wire logic               in_rise,
	input  wire logic               in_fall,
	input  wire logic               dir_edge,
	input  wire logic               chain_en,
	input  wire logic               chain_evt,
	input  wire logic               hold,
	// Overwrite paths
	input  wire logic               cpu_wr,
	input  wire logic [W-1:0]       cpu_val,
	input  wire logic               load,
	input  wire logic [W-1:0]       load_val,
	// Results
	output logic [W-1:0]            count_reg,
	output logic                    wrap_now,
	output logic                    wrap_reg
);
	import ttc_pkg::*;

	logic         gate_ok;
	logic         pin_evt;
	logic         pend_reg;
	logic         timed;
	logic         step;
	logic         at_end;
	logic [W-1:0] count_next;

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	always_comb begin
		case (mode)
			TTC_M_GATE_LO: gate_ok = !in_lvl;
			TTC_M_GATE_HI: gate_ok = in_lvl;
			default:       gate_ok = 1'b1;
		endcase
	end

	// Reserved codes 100 and 101 give no events and so hold the count
	always_comb begin
		case (mode)
			TTC_M_COUNTER: pin_evt = (edge_sel[0] & in_rise) | (edge_sel[1] & in_fall);
			TTC_M_INC_ROT: pin_evt = in_rise | in_fall;
			TTC_M_INC_EDG: pin_evt = in_rise | in_fall | dir_edge;
			default:       pin_evt = 1'b0;
		endcase
	end

	assign timed = (mode == TTC_M_TIMER) || (mode == TTC_M_GATE_LO) || (mode == TTC_M_GATE_HI);

	// Pin events wait for the quarter strobe; two edges in one window count once
	always_ff @(posedge aclk) begin
		if (!aresetn || !run || q4_tick) begin
			pend_reg <= 1'b0;
		end else if (pin_evt) begin
			pend_reg <= 1'b1;
		end
	end

	always_comb begin
		if (chain_en) begin
			step = chain_evt;
		end else if (timed) begin
			step = base_tick & gate_ok;
		end else begin
			step = q4_tick & (pend_reg | pin_evt);
		end
		step = step & run & !hold;
	end

	assign at_end = down ? (count_reg == '0) : (count_reg == '1);
	assign wrap_now = step & at_end & !cpu_wr;

	always_comb begin
		if (cpu_wr) begin
			count_next = cpu_val;
		end else if (load) begin
			count_next = load_val;
		end else if (step) begin
			count_next = down ? count_reg - 1'b1 : count_reg + 1'b1;
		end else begin
			count_next = count_reg;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			count_reg <= `TTC_RST_CNT;
		end else begin
			count_reg <= count_next;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wrap_reg <= 1'b0;
		end else begin
			wrap_reg <= wrap_now;
		end
	end

	AST_CPU_WINS: assert property (cpu_wr |=> count_reg == $past(cpu_val))
		else $error("Software write lost against a hardware update");
	AST_STOPPED: assert property ((!run && !cpu_wr && !load) |=> $stable(count_reg))
		else $error("Count moved while the run bit was clear");
	AST_UP_STEP: assert property ((step && !down && !cpu_wr && !load)
		|=> count_reg == $past(count_reg) + 1'b1)
		else $error("Up step did not add one");
	AST_DOWN_STEP: assert property ((step && down && !cpu_wr && !load)
		|=> count_reg == $past(count_reg) - 1'b1)
		else $error("Down step did not subtract one");
	AST_GATE_SHUT: assert property ((mode == TTC_M_GATE_HI && !in_lvl && !chain_en
		&& !cpu_wr && !load) |=> $stable(count_reg))
		else $error("Gated timer counted with its gate closed");
	AST_WRAP_FLAG: assert property ((wrap_reg && !$past(load)) |->
		(count_reg == '0 && $past(count_reg) == '1) ||
		(count_reg == '1 && $past(count_reg) == '0))
		else $error("Wrap flagged without a wrap of the count");
endmodule

// ==== ttc_top.sv ====
// Three-timer block: core and two auxiliary 16-bit timers behind an AXI4-Lite slave.
// Assumes pins are asynchronous to aclk; interrupt priority lives outside.
//
// Implementation choices: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/10ps
`include "ttc_defs.svh"
module ttc_top #(
	parameter int ADDR_W = 8
) (
	// Clock and reset
	input  wire logic              aclk,
	input  wire logic              aresetn,
	// AXI4-Lite write channels
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	// AXI4-Lite read channels
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	// Pins, index 0 core, 1 low auxiliary, 2 high auxiliary
	input  wire logic [2:0]        timer_input_pin,
	input  wire logic [2:0]        external_direction_input,
	output logic                   toggle_output_pin,
	output logic                   toggle_output_oe,
	// Interrupts
	output logic [2:0]             timer_irq,
	output logic                   irq
);
	import ttc_pkg::*;

	localparam int NT    = 3;
	localparam int W     = `TTC_CNT_W;
	localparam int S_STS = 6;
	localparam int S_MSK = 7;

	logic [5:0]      sync1_reg;
	logic [5:0]      sync2_reg;
	logic [5:0]      sync3_reg;
	logic [NT-1:0]   in_lvl;
	logic [NT-1:0]   eud_lvl;
	logic [NT-1:0]   in_rise;
	logic [NT-1:0]   in_fall;
	logic [NT-1:0]   eud_edge;
	logic [4:0]      presc_reg;
	logic [4:0]      presc_mask;
	logic [1:0]      presc_sel;
	logic            base_tick;
	logic            q4_tick;
	logic            aw_full_reg;
	logic            w_full_reg;
	logic [ADDR_W-1:0] awaddr_reg;
	logic [31:0]     wdata_reg;
	logic [3:0]      wstrb_reg;
	logic            bvalid_reg;
	logic [1:0]      bresp_reg;
	logic            rvalid_reg;
	logic [1:0]      rresp_reg;
	logic [31:0]     rdata_reg;
	logic [31:0]     rd_word;
	logic            wr_go;
	logic [7:0]      wsel;
	logic [7:0]      rsel;
	logic [W-1:0]    ctrl_reg [NT];
	logic [W-1:0]    ctrl_view [NT];
	logic [W-1:0]    cnt [NT];
	logic [W-1:0]    cpu_val [NT];
	logic [W-1:0]    load_val [NT];
	logic            cpu_wr [NT];
	logic            load [NT];
	logic            hold [NT];
	logic            chain_en [NT];
	logic            down [NT];
	logic            wrap_now [NT];
	logic            wrap_p [NT];
	ttc_aux_t        aux_f [NT];
	logic [NT-1:0]   wrap_vec;
	logic            rel1;
	logic            rel2;
	logic            latch_reg;
	logic            latch_q_reg;
	logic            chain_evt;
	logic            pin_reg;
	logic [NT-1:0]   sts_reg;
	logic [NT-1:0]   msk_reg;
	logic [NT-1:0]   w1c;

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// One-hot register select; zero marks an unmapped address
	function automatic logic [7:0] reg_sel(input logic [ADDR_W-1:0] a);
		logic [ADDR_W-1:0] w;
		w = {a[ADDR_W-1:2], 2'b00};
		case (w)
			ADDR_W'(`TTC_OFF_CTRL0): reg_sel = 8'h01;
			ADDR_W'(`TTC_OFF_CTRL1): reg_sel = 8'h02;
			ADDR_W'(`TTC_OFF_CTRL2): reg_sel = 8'h04;
			ADDR_W'(`TTC_OFF_CNT0):  reg_sel = 8'h08;
			ADDR_W'(`TTC_OFF_CNT1):  reg_sel = 8'h10;
			ADDR_W'(`TTC_OFF_CNT2):  reg_sel = 8'h20;
			ADDR_W'(`TTC_OFF_STS):   reg_sel = 8'h40;
			ADDR_W'(`TTC_OFF_MSK):   reg_sel = 8'h80;
			default:                 reg_sel = 8'h00;
		endcase
	endfunction

	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
		input logic [3:0] s);
		merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
	endfunction

	// Pin xor software bit when the pin is enabled, else software bit alone
	function automatic logic dir_down(input logic [15:0] c, input logic eud);
		dir_down = c[`TTC_F_UDE] ? (eud ^ c[`TTC_F_UD]) : c[`TTC_F_UD];
	endfunction

	// Pin synchronisers; the third stage only serves edge detection
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sync1_reg <= 6'h00;
			sync2_reg <= 6'h00;
			sync3_reg <= 6'h00;
		end else begin
			sync1_reg <= {external_direction_input, timer_input_pin};
			sync2_reg <= sync1_reg;
			sync3_reg <= sync2_reg;
		end
	end

	assign in_lvl   = sync2_reg[2:0];
	assign eud_lvl  = sync2_reg[5:3];
	assign in_rise  = sync2_reg[2:0] & ~sync3_reg[2:0];
	assign in_fall  = ~sync2_reg[2:0] & sync3_reg[2:0];
	assign eud_edge = sync2_reg[5:3] ^ sync3_reg[5:3];

	// Free-running prescaler; the /4 select is also the fastest count rate
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			presc_reg <= 5'h00;
		end else begin
			presc_reg <= presc_reg + 5'h01;
		end
	end

	assign presc_sel = ctrl_reg[0][`TTC_F_BPS_HI:`TTC_F_BPS_LO];

	always_comb begin
		unique case (presc_sel)
			2'h0: presc_mask = 5'(`TTC_DIV_SEL0 - 1);
			2'h1: presc_mask = 5'(`TTC_DIV_SEL1 - 1);
			2'h2: presc_mask = 5'(`TTC_DIV_SEL2 - 1);
			2'h3: presc_mask = 5'(`TTC_DIV_SEL3 - 1);
		endcase
	end

	assign base_tick = (presc_reg & presc_mask) == presc_mask;
	assign q4_tick   = (presc_reg & 5'(`TTC_MIN_DIV - 1)) == 5'(`TTC_MIN_DIV - 1);

	// Write address and data are taken in either order; the write fires once both are held
	assign s_axi_awready = !aw_full_reg && !bvalid_reg;
	assign s_axi_wready  = !w_full_reg && !bvalid_reg;
	assign wr_go         = aw_full_reg && w_full_reg && !bvalid_reg;
	assign wsel          = reg_sel(awaddr_reg);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_full_reg <= 1'b0;
			awaddr_reg  <= '0;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_full_reg <= 1'b1;
			awaddr_reg  <= s_axi_awaddr;
		end else if (wr_go) begin
			aw_full_reg <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_full_reg <= 1'b0;
			wdata_reg  <= 32'h0;
			wstrb_reg  <= 4'h0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_full_reg <= 1'b1;
			wdata_reg  <= s_axi_wdata;
			wstrb_reg  <= s_axi_wstrb;
		end else if (wr_go) begin
			w_full_reg <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_reg <= 1'b0;
			bresp_reg  <= `TTC_RESP_OKAY;
		end else if (wr_go) begin
			bvalid_reg <= 1'b1;
			bresp_reg  <= (wsel == 8'h00) ? `TTC_RESP_ERR : `TTC_RESP_OKAY;
		end else if (s_axi_bready) begin
			bvalid_reg <= 1'b0;
		end
	end

	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp  = bresp_reg;

	// Read side: one read in flight, answered the cycle after the address is taken
	assign s_axi_arready = !rvalid_reg;
	assign rsel          = reg_sel(s_axi_araddr);

	always_comb begin
		rd_word = 32'h0;
		for (int i = 0; i < NT; i++) begin
			if (rsel[i]) begin
				rd_word = {16'h0, ctrl_view[i]};
			end
			if (rsel[NT+i]) begin
				rd_word = {16'h0, cnt[i]};
			end
		end
		if (rsel[S_STS]) begin
			rd_word = {29'h0, sts_reg};
		end
		if (rsel[S_MSK]) begin
			rd_word = {29'h0, msk_reg};
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_reg <= 1'b0;
			rresp_reg  <= `TTC_RESP_OKAY;
			rdata_reg  <= 32'h0;
		end else if (s_axi_arvalid && s_axi_arready) begin
			rvalid_reg <= 1'b1;
			rresp_reg  <= (rsel == 8'h00) ? `TTC_RESP_ERR : `TTC_RESP_OKAY;
			rdata_reg  <= rd_word;
		end else if (s_axi_rready) begin
			rvalid_reg <= 1'b0;
		end
	end

	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rresp  = rresp_reg;
	assign s_axi_rdata  = rdata_reg;

	// Auxiliary functions; the lower auxiliary wins if both ask to reload the core
	assign rel1 = aux_f[1] == TTC_AUX_RELOAD;
	assign rel2 = aux_f[2] == TTC_AUX_RELOAD;

	for (genvar i = 0; i < NT; i++) begin : g_tmr
		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				ctrl_reg[i] <= `TTC_RST_CTRL;
			end else if (wr_go && wsel[i]) begin
				ctrl_reg[i] <= merge16(ctrl_reg[i], wdata_reg, wstrb_reg);
			end
		end

		assign aux_f[i]    = (i == 0) ? TTC_AUX_SOLO :
			ttc_aux_t'(ctrl_reg[i][`TTC_F_AUX_HI:`TTC_F_AUX_LO]);
		assign down[i]     = dir_down(ctrl_reg[i], eud_lvl[i]);
		assign cpu_wr[i]   = wr_go && wsel[NT+i] && (wstrb_reg[1:0] != 2'h0);
		assign cpu_val[i]  = merge16(cnt[i], wdata_reg, wstrb_reg);
		assign chain_en[i] = aux_f[i] == TTC_AUX_CONCAT;
		assign hold[i]     = (aux_f[i] == TTC_AUX_RELOAD) || (aux_f[i] == TTC_AUX_CAPTURE);
		assign load[i]     = (i == 0) ? (wrap_now[0] && (rel1 || rel2)) :
			(aux_f[i] == TTC_AUX_CAPTURE && in_rise[i]);
		assign load_val[i] = (i == 0) ? (rel1 ? cnt[1] : cnt[2]) : cnt[0];
		assign ctrl_view[i] = {down[i], 2'b00,
			(i == 0) ? {ctrl_reg[i][12:11], latch_reg} : {2'b00, ctrl_reg[i][10]},
			ctrl_reg[i][9:0]};

		ttc_timer #(
			.W(W)
		) u_tmr (
			.aclk      (aclk),
			.aresetn   (aresetn),
			.mode      (ttc_mode_t'(ctrl_reg[i][`TTC_F_MODE_HI:`TTC_F_MODE_LO])),
			.edge_sel  (ctrl_reg[i][`TTC_F_EDGE_HI:`TTC_F_EDGE_LO]),
			.run       (ctrl_reg[i][`TTC_F_RUN]),
			.down      (down[i]),
			.base_tick (base_tick),
			.q4_tick   (q4_tick),
			.in_lvl    (in_lvl[i]),
			.in_rise   (in_rise[i]),
			.in_fall   (in_fall[i]),
			.dir_edge  (eud_edge[i]),
			.chain_en  (chain_en[i]),
			.chain_evt (chain_evt),
			.hold      (hold[i]),
			.cpu_wr    (cpu_wr[i]),
			.cpu_val   (cpu_val[i]),
			.load      (load[i]),
			.load_val  (load_val[i]),
			.count_reg (cnt[i]),
			.wrap_now  (wrap_now[i]),
			.wrap_reg  (wrap_p[i])
		);
	end

	// Latch write by software beats a same-cycle toggle
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			latch_reg <= 1'b0;
		end else if (wr_go && wsel[0] && wstrb_reg[1]) begin
			latch_reg <= wdata_reg[`TTC_F_LATCH];
		end else if (wrap_now[0]) begin
			latch_reg <= !latch_reg;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			latch_q_reg <= 1'b0;
			pin_reg     <= 1'b0;
		end else begin
			latch_q_reg <= latch_reg;
			pin_reg     <= ctrl_reg[0][`TTC_F_OE] & latch_reg;
		end
	end

	assign chain_evt         = latch_reg ^ latch_q_reg;
	assign toggle_output_pin = pin_reg;
	assign toggle_output_oe  = ctrl_reg[0][`TTC_F_OE];

	// Sticky status, write one to clear; a new wrap wins over the clear
	always_comb begin
		for (int i = 0; i < NT; i++) begin
			wrap_vec[i] = wrap_p[i];
		end
	end

	assign w1c = (wr_go && wsel[S_STS] && wstrb_reg[0]) ? wdata_reg[NT-1:0] : '0;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sts_reg <= '0;
		end else begin
			sts_reg <= (sts_reg & ~w1c) | wrap_vec;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			msk_reg <= '0;
		end else if (wr_go && wsel[S_MSK] && wstrb_reg[0]) begin
			msk_reg <= wdata_reg[NT-1:0];
		end
	end

	assign timer_irq = wrap_vec;
	assign irq       = |(sts_reg & msk_reg);

	AST_PRESC_GAP: assert property (base_tick |=> !base_tick [*3])
		else $error("Base ticks closer than four clocks");
	AST_PRESC_DIV32: assert property ((base_tick && presc_sel == 2'h2)
		|-> presc_reg == 5'h1f)
		else $error("Divide by 32 ticked off its boundary");
	AST_LATCH_TOGGLE: assert property ((wrap_now[0] && !(wr_go && wsel[0]))
		|=> latch_reg != $past(latch_reg))
		else $error("Core wrap did not toggle the latch");
	AST_PIN_FOLLOWS: assert property ($past(toggle_output_oe)
		|-> toggle_output_pin == $past(latch_reg))
		else $error("Output pin does not show the latch");
	AST_RELOAD: assert property ((wrap_now[0] && rel1 && !cpu_wr[0])
		|=> cnt[0] == $past(cnt[1]))
		else $error("Core did not reload from the low auxiliary timer");
	AST_CAPTURE: assert property ((aux_f[1] == TTC_AUX_CAPTURE && in_rise[1] && !cpu_wr[1])
		|=> cnt[1] == $past(cnt[0]))
		else $error("Low auxiliary timer did not capture the core");
	AST_IRQ_LINE: assert property (wrap_now[0] |=> timer_irq[0]
		##1 (!timer_irq[0] || $past(wrap_now[0])))
		else $error("Core request line did not pulse after a wrap");
	AST_STS_SET_WINS: assert property (wrap_vec[0] |=> sts_reg[0])
		else $error("Wrap event lost from the status register");
	AST_BRESP: assert property (wr_go |=> s_axi_bvalid)
		else $error("Write response missing after a write");
endmodule
